/* File: shared/instr_timing_pkg.sv */
// constants, opcode classes and timing figures for the execution timing engine
// assumes one system clock and a bus that completes each access in two clocks
package instr_timing_pkg;

   typedef enum logic [4:0] {
      OP_ALU_REG    = 5'h00,
      OP_ALU_MEM    = 5'h01,
      OP_MUL_W      = 5'h02,
      OP_DIVU_W     = 5'h03,
      OP_DIVS_W     = 5'h04,
      OP_MUL_L32    = 5'h05,
      OP_MUL_L64    = 5'h06,
      OP_DIVU_L     = 5'h07,
      OP_DIVS_L     = 5'h08,
      OP_TBL_RND    = 5'h09,
      OP_TBL_SRAW   = 5'h0a,
      OP_TBL_URAW   = 5'h0b,
      OP_DEC_MEM    = 5'h0c,
      OP_EXT_MEM    = 5'h0d,
      OP_ATOMIC_MEM = 5'h0e,
      OP_ATOMIC_REG = 5'h0f,
      OP_SHIFT_IMM  = 5'h10,
      OP_SHIFT_MEM  = 5'h11,
      OP_SHIFT_REG  = 5'h12,
      OP_ROTX_REG   = 5'h13,
      OP_ROTX_IMM   = 5'h14,
      OP_ALT_MOVE   = 5'h15
   } op_class_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RUN   = 2'b01,
      ST_DONE  = 2'b10
   } state_type;

   localparam int BUS_CLOCKS     = 2;   // every access
   localparam int LONG_EXTRA     = 2;   // clocks per extra long access
   localparam int SLOW_BUS_LIMIT = 4;   // starred word move-multiple cycle
   localparam int SAVE_HEAD      = 1;
   localparam int SAVE_TAIL      = 1;
   localparam int SAVE_CYC       = 3;
   localparam int CNT_W          = 8;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

endpackage

/* File: design/instr_timing.sv */
// execution timing engine: computes head, tail and total clocks and plays out the total
// assumes the issuing core holds operands stable while START is sampled
`timescale 1ns/100ps
module instr_timing #(
   parameter int CNT_W = 8
) (
   input  wire logic                              SYS_CLK,
   input  wire logic                              RESETN,
   input  wire logic                              START,
   input  wire instr_timing_pkg::op_class_type    OP_CLASS,
   input  wire logic                              LONG_OP,
   input  wire logic                              MEM_OPERAND,
   input  wire logic                              SIGNED_OP,
   input  wire logic [5:0]                        SHIFT_COUNT,
   input  wire logic [7:0]                        EA_HEAD,
   input  wire logic [7:0]                        EA_TAIL,
   input  wire logic [7:0]                        EA_CYCLES,
   input  wire logic [7:0]                        EARLY_FINISH,
   input  wire logic [7:0]                        PREV_TAIL,
   input  wire logic [7:0]                        EXTRA_BUS,
   output logic                                   BUSY,
   output logic                                   DONE,
   output logic [7:0]                             HEAD,
   output logic [7:0]                             TAIL,
   output logic [7:0]                             TOTAL,
   output logic [3:0]                             READS,
   output logic [3:0]                             PREFETCHES,
   output logic [3:0]                             WRITES
);
   import instr_timing_pkg::*;

   // the longest total must fit the play-out counter, a narrower one would wrap
   if (CNT_W < 8) begin
      $error("CNT_W too narrow for timing counts");
   end

   typedef struct packed {
      logic [7:0] h;
      logic [7:0] t;
      logic [7:0] c;
      logic [3:0] r;
      logic [3:0] p;
      logic [3:0] w;
      logic       save;
   } seg_type;

   // overlap of a following head with a preceding tail
   function automatic logic [7:0] overlap(input logic [7:0] tail_prev, input logic [7:0] head_next);
      overlap = (tail_prev < head_next) ? tail_prev : head_next;
   endfunction

   // register-count shift time, flat except for the count-dependent forms
   function automatic logic [7:0] shift_cycles(input logic [5:0] n, input logic rotx, input logic imm);
      logic [7:0] v;
      v = 8'h00;
      if (rotx && imm) begin
         v = 8'(2 + n + n[0]);
      end else if (rotx) begin
         // parity term kept one bit wide; an inverted bit would widen first
         v = 8'(3 + n + (n[0] ? 1'b0 : 1'b1));
      end else begin
         v = 8'(3 + (n >> 2) + n[1:0] + (((n >> 2) + n[1:0] + 1) & 6'h01));
      end
      shift_cycles = (v < 8'h06) ? 8'h06 : v;
   endfunction

   seg_type    op_seg;
   logic [7:0] long_adj;

   // operation segment lookup
   always_comb begin
      op_seg   = '{h: 8'h00, t: 8'h00, c: 8'h02, r: 4'h0, p: 4'h1, w: 4'h0, save: 1'b0};
      long_adj = LONG_OP ? 8'(LONG_EXTRA) : 8'h00;
      case (OP_CLASS)
         OP_ALU_REG:   op_seg.c = 8'h02;
         OP_ALU_MEM: begin
            op_seg.t = 8'h03 + long_adj;
            op_seg.c = 8'h05 + long_adj;
            op_seg.w = LONG_OP ? 4'h2 : 4'h1;
         end
         OP_MUL_W:     op_seg.c = 8'h1a;
         OP_DIVU_W:    op_seg.c = 8'h20;
         OP_DIVS_W:    op_seg.c = 8'h2a;
         OP_MUL_L32, OP_MUL_L64: begin
            op_seg.h    = 8'h02;
            op_seg.c    = (OP_CLASS == OP_MUL_L64) ? 8'h2e : 8'h34;
            op_seg.save = MEM_OPERAND;
         end
         OP_DIVU_L, OP_DIVS_L: begin
            op_seg.h    = 8'h02;
            op_seg.c    = (OP_CLASS == OP_DIVS_L) ? 8'h3e : 8'h2e;
            op_seg.save = MEM_OPERAND;
         end
         OP_TBL_RND: begin
            op_seg.h = 8'h1a;
            op_seg.c = 8'h1e;
            op_seg.p = 4'h2;
         end
         OP_TBL_SRAW: begin
            op_seg.h = 8'h1e;
            op_seg.c = 8'h22;
            op_seg.p = 4'h2;
         end
         OP_TBL_URAW: begin
            op_seg.h = 8'h1e;
            op_seg.c = 8'h28;
            op_seg.p = 4'h2;
         end
         OP_DEC_MEM, OP_EXT_MEM: begin
            op_seg.h = 8'h02;
            op_seg.t = 8'h02;
            op_seg.c = (OP_CLASS == OP_DEC_MEM) ? 8'h0c : 8'h0a;
            op_seg.r = 4'h2;
            op_seg.w = 4'h1;
         end
         OP_ATOMIC_MEM: begin
            op_seg.h = 8'h01;
            op_seg.c = 8'h0a;
            op_seg.w = 4'h1;
         end
         OP_ATOMIC_REG: begin
            op_seg.h = 8'h04;
            op_seg.c = 8'h06;
         end
         OP_SHIFT_IMM: begin
            op_seg.h = 8'h04;
            op_seg.c = 8'h06;
         end
         OP_SHIFT_MEM: begin
            op_seg.t = 8'h02;
            op_seg.c = 8'h06;
            op_seg.w = 4'h1;
         end
         OP_SHIFT_REG, OP_ROTX_REG, OP_ROTX_IMM: begin
            op_seg.c = shift_cycles(SHIFT_COUNT, OP_CLASS != OP_SHIFT_REG, OP_CLASS == OP_ROTX_IMM);
            op_seg.h = op_seg.c - 8'h02;
         end
         OP_ALT_MOVE: begin
            op_seg.h    = MEM_OPERAND ? 8'h07 : 8'h09;
            op_seg.t    = MEM_OPERAND ? 8'h01 : 8'h02;
            op_seg.c    = MEM_OPERAND ? 8'h0b : 8'h0c;
            op_seg.save = 1'b1;
         end
         default:      op_seg.c = 8'h02;
      endcase
      // maximum entries may finish early, never late
      if ((OP_CLASS inside {OP_DIVU_L, OP_DIVS_L, OP_MUL_L32, OP_TBL_RND, OP_TBL_SRAW, OP_TBL_URAW})
          && (EARLY_FINISH < op_seg.c - op_seg.h))
         op_seg.c = op_seg.c - EARLY_FINISH;
   end

   // segment chain: save, address, operation with overlap
   logic [7:0] sum_total;
   logic [7:0] sum_head;
   logic [7:0] sum_tail;
   logic [7:0] run_tail;
   logic [7:0] slow_head;
   logic [7:0] slow_over;

   always_comb begin
      sum_total = 8'h00;
      run_tail  = PREV_TAIL;
      sum_head  = 8'h00;
      if (op_seg.save) begin
         sum_total = 8'(SAVE_CYC) - overlap(run_tail, 8'(SAVE_HEAD));
         sum_head  = 8'(SAVE_HEAD);
         run_tail  = 8'(SAVE_TAIL);
      end
      // address step, supplied by the core's address tables
      sum_total = sum_total + EA_CYCLES - overlap(run_tail, EA_HEAD);
      if (!op_seg.save)
         sum_head = EA_HEAD;
      if (EA_CYCLES != 8'h00)
         run_tail = EA_TAIL;
      // long operand clocks already sit in op_seg.c, so none are added here
      sum_total = sum_total + op_seg.c - overlap(run_tail, op_seg.h);
      if (!op_seg.save && EA_CYCLES == 8'h00)
         sum_head = op_seg.h;
      sum_tail  = op_seg.t;
      // slower bus: eat head first, then grow tail and total
      slow_head = (EXTRA_BUS < sum_head) ? EXTRA_BUS : sum_head;
      slow_over = EXTRA_BUS - slow_head;
      sum_head  = sum_head - slow_head;
      sum_tail  = sum_tail + slow_over;
      sum_total = sum_total + slow_over;
   end

   // play-out state: busy for one clock less than the total count, then done for one clock
   state_type        state_reg,  state_next;
   logic [CNT_W-1:0] count_reg,  count_next;
   logic [7:0]       head_reg,   head_next;
   logic [7:0]       tail_reg,   tail_next;
   logic [7:0]       total_reg,  total_next;
   logic [11:0]      rpw_reg,    rpw_next;

   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      head_next  = head_reg;
      tail_next  = tail_reg;
      total_next = total_reg;
      rpw_next   = rpw_reg;
      case (state_reg)
         ST_IDLE, ST_DONE: begin
            state_next = ST_IDLE;
            if (START) begin
               head_next  = sum_head;
               tail_next  = sum_tail;
               total_next = sum_total;
               rpw_next   = {op_seg.r, op_seg.p + 4'(op_seg.save), op_seg.w};
               count_next = CNT_W'(sum_total);
               state_next = (sum_total > 8'h01) ? ST_RUN : ST_DONE;
            end
         end
         ST_RUN: begin
            count_next = count_reg - 1'b1;
            if (count_reg <= CNT_W'(2))
               state_next = ST_DONE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= ST_IDLE;
         count_reg <= CNT_W'(CNT_RESET);
         head_reg  <= 8'h00;
         tail_reg  <= 8'h00;
         total_reg <= 8'h00;
         rpw_reg   <= 12'h000;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         head_reg  <= head_next;
         tail_reg  <= tail_next;
         total_reg <= total_next;
         rpw_reg   <= rpw_next;
      end
   end

   // outputs; decoded from the play-out state and the registered results of the last start
   assign BUSY       = (state_reg == ST_RUN);
   assign DONE       = (state_reg == ST_DONE);
   assign HEAD       = head_reg;
   assign TAIL       = tail_reg;
   assign TOTAL      = total_reg;
   assign READS      = rpw_reg[11:8];
   assign PREFETCHES = rpw_reg[7:4];
   assign WRITES     = rpw_reg[3:0];

endmodule

/* File: tb/bus_model.sv */
// slow bus stand-in: turns clocks per access into extra clocks for the engine
// assumes the bench sets clocks per access and the access count between runs
`timescale 1ns/100ps
module bus_model (
   input  wire logic       SYS_CLK,
   input  wire logic       RESETN,
   input  wire logic [3:0] access_clocks,
   input  wire logic [3:0] accesses,
   output logic      [7:0] extra_bus
);
   logic [7:0] extra_reg, extra_next;
   // two clocks per access is nominal, so only the excess is reported
   always_comb begin
      extra_next = 8'h00;
      if (access_clocks > 4'h2) extra_next = accesses * (access_clocks - 4'h2);
   end
   // registered so the figure is settled before the next start
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) extra_reg <= 8'h00;
      else extra_reg <= extra_next;
   end
   assign extra_bus = extra_reg;
endmodule

/* File: tb/timing_checker.sv */
// assertions on the timing engine ports
// assumes binding onto instr_timing, one clock domain
`timescale 1ns/100ps
module timing_checker #(
   parameter int CNT_W = 8
) (
   input wire logic                           SYS_CLK,
   input wire logic                           RESETN,
   input wire logic                           START,
   input wire instr_timing_pkg::op_class_type OP_CLASS,
   input wire logic [7:0]                     EA_CYCLES,
   input wire logic [7:0]                     EARLY_FINISH,
   input wire logic [7:0]                     PREV_TAIL,
   input wire logic [7:0]                     EXTRA_BUS,
   input wire logic                           BUSY,
   input wire logic                           DONE,
   input wire logic [7:0]                     HEAD,
   input wire logic [7:0]                     TOTAL,
   input wire logic [3:0]                     READS,
   input wire logic [3:0]                     PREFETCHES,
   input wire logic [3:0]                     WRITES
);
   import instr_timing_pkg::*;
   logic [7:0] since_reg;
   logic       take, plain;
   // plain start: no address step, overlap, slow bus or early finish
   assign take = START && !BUSY;
   assign plain = take && EA_CYCLES == 8'h00 && PREV_TAIL == 8'h00 && EXTRA_BUS == 8'h00 && EARLY_FINISH == 8'h00;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   // clocks since the last accepted start, restarted on each take
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) since_reg <= 8'h00;
      else if (take) since_reg <= 8'h00;
      else since_reg <= since_reg + 8'h01;
   end
   a_done_timing: assert property (DONE && TOTAL > 8'h01 |-> since_reg == TOTAL - 8'h01)
      else $error("done pulse not at total clocks");
   a_done_single: assert property (DONE |=> !DONE)
      else $error("done pulse longer than one cycle");
   a_bus_included: assert property (DONE |-> TOTAL >= 8'h02 * (READS + PREFETCHES + WRITES))
      else $error("total smaller than its bus cycles");
   a_results_stand: assert property ($past(RESETN) && !$past(take) |->
      $stable(TOTAL) && $stable(HEAD))
      else $error("results changed without a start");
   a_alu_reg: assert property (plain && OP_CLASS == OP_ALU_REG |=>
      TOTAL == 8'h02 && PREFETCHES == 4'h1 && WRITES == 4'h0)
      else $error("register alu timing wrong");
   a_word_mul: assert property (plain && OP_CLASS == OP_MUL_W |=>
      TOTAL == 8'h1a && HEAD == 8'h00)
      else $error("word multiply timing wrong");
   a_atomic_reg: assert property (plain && OP_CLASS == OP_ATOMIC_REG |=>
      TOTAL == 8'h06 && HEAD == 8'h04)
      else $error("register test-and-set timing wrong");
   a_shift_imm: assert property (plain && OP_CLASS == OP_SHIFT_IMM |=>
      TOTAL == 8'h06 && HEAD == 8'h04)
      else $error("immediate shift timing wrong");
endmodule
bind instr_timing timing_checker #(.CNT_W(CNT_W)) chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .START(START),
   .OP_CLASS(OP_CLASS), .EA_CYCLES(EA_CYCLES), .EARLY_FINISH(EARLY_FINISH), .PREV_TAIL(PREV_TAIL),
   .EXTRA_BUS(EXTRA_BUS), .BUSY(BUSY), .DONE(DONE), .HEAD(HEAD), .TOTAL(TOTAL), .READS(READS),
   .PREFETCHES(PREFETCHES), .WRITES(WRITES));

/* File: tb/testbench.sv */
// self-checking bench for the timing engine, slow bus model on the far side
// assumes a 10 MHz clock and a 20-cycle reset at the start
`timescale 1ns/100ps
module testbench;
   import instr_timing_pkg::*;
   logic         clk = 1'b0, rstn = 1'b0, start = 1'b0, lng = 1'b0, mem = 1'b0, sgn = 1'b0;
   op_class_type op = OP_ALU_REG;
   logic [5:0]   cnt = 6'h00;
   logic [7:0]   eah = 8'h00, eat = 8'h00, eac = 8'h00, early = 8'h00, prev = 8'h00, extra;
   logic [3:0]   acc_clk = 4'h2, accs = 4'h0, rd, pf, wr;
   logic         busy, done;
   logic [7:0]   head, tail, total;
   int           fail_count = 0, checks_done = 0;
   always #50 clk = ~clk;
   bus_model bus (.SYS_CLK(clk), .RESETN(rstn), .access_clocks(acc_clk), .accesses(accs), .extra_bus(extra));
   instr_timing dut (.SYS_CLK(clk), .RESETN(rstn), .START(start), .OP_CLASS(op), .LONG_OP(lng),
      .MEM_OPERAND(mem), .SIGNED_OP(sgn), .SHIFT_COUNT(cnt), .EA_HEAD(eah), .EA_TAIL(eat), .EA_CYCLES(eac),
      .EARLY_FINISH(early), .PREV_TAIL(prev), .EXTRA_BUS(extra), .BUSY(busy), .DONE(done), .HEAD(head),
      .TAIL(tail), .TOTAL(total), .READS(rd), .PREFETCHES(pf), .WRITES(wr));
   task conclude();
      if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] got, logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %0d exp %0d", $time, got, exp);
      end
   endtask
   task chkb(input logic [3:0] got, logic [3:0] exp);
      chk({4'h0, got}, {4'h0, exp});
   endtask
   // one accepted start, then a bounded wait for the done pulse
   task run(input op_class_type o, logic l, logic m, logic [5:0] c, logic [7:0] p);
      @(posedge clk);
      op <= o;
      lng <= l;
      mem <= m;
      cnt <= c;
      prev <= p;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      // every total here exceeds one clock, so the engine counts after the take
      @(negedge clk);
      chk({7'h00, busy}, 8'h01);
      repeat (100) begin
         @(negedge clk);
         if (done === 1'b1) break;
      end
      chk({7'h00, done}, 8'h01);
   endtask
   task s_alu();
      run(OP_ALU_REG, 1'b0, 1'b0, 6'h00, 8'h00);
      chk(total, 8'h02);
      chkb(pf, 4'h1);
      chkb(rd, 4'h0);
      run(OP_ALU_MEM, 1'b0, 1'b1, 6'h00, 8'h00);
      chk(tail, 8'h03);
      chk(total, 8'h05);
      chkb(wr, 4'h1);
      run(OP_ALU_MEM, 1'b1, 1'b1, 6'h00, 8'h00);
      chk(tail, 8'h05);
      chk(total, 8'h07);
      chkb(wr, 4'h2);
   endtask
   // fixed-timing classes from one table: total, head, writes
   task s_fixed();
      op_class_type ops[13] = '{OP_DEC_MEM, OP_EXT_MEM, OP_ATOMIC_MEM, OP_ATOMIC_REG, OP_SHIFT_IMM, OP_SHIFT_MEM,
         OP_MUL_W, OP_DIVU_W, OP_DIVS_W, OP_DIVU_L, OP_DIVS_L, OP_MUL_L64, OP_MUL_L32};
      logic [7:0] tot[13] = '{8'h0c, 8'h0a, 8'h0a, 8'h06, 8'h06, 8'h06, 8'h1a, 8'h20, 8'h2a, 8'h2e, 8'h3e, 8'h2e, 8'h34};
      logic [7:0] hd[13] = '{8'h02, 8'h02, 8'h01, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h02, 8'h02};
      logic [3:0] w[13] = '{4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
      for (int i = 0; i < 13; i++) begin
         run(ops[i], 1'b0, 1'b0, 6'h00, 8'h00);
         chk(total, tot[i]);
         chk(head, hd[i]);
         chkb(wr, w[i]);
      end
      chkb(rd, 4'h0);
      @(posedge clk) sgn <= 1'b1;
      run(OP_MUL_W, 1'b0, 1'b0, 6'h00, 8'h00);
      chk(total, 8'h1a);
   endtask
   // count-dependent shift forms and one count-independent form
   task s_shift();
      op_class_type ops[7] = '{OP_SHIFT_IMM, OP_SHIFT_REG, OP_SHIFT_REG, OP_SHIFT_REG, OP_ROTX_REG, OP_ROTX_REG,
         OP_ROTX_IMM};
      logic [5:0] c[7] = '{6'h3f, 6'h00, 6'h07, 6'h3f, 6'h00, 6'h0a, 6'h08};
      logic [7:0] tot[7] = '{8'h06, 8'h06, 8'h08, 8'h16, 8'h06, 8'h0e, 8'h0a};
      for (int i = 0; i < 7; i++) begin
         run(ops[i], 1'b0, 1'b0, c[i], 8'h00);
         chk(total, tot[i]);
         chk(head, (i == 0) ? 8'h04 : tot[i] - 8'h02);
      end
   endtask
   task s_table();
      op_class_type ops[3] = '{OP_TBL_RND, OP_TBL_SRAW, OP_TBL_URAW};
      logic [7:0] lo[3] = '{8'h1c, 8'h1e, 8'h22};
      logic [7:0] hi[3] = '{8'h1e, 8'h22, 8'h28};
      for (int i = 0; i < 3; i++) begin
         run(ops[i], 1'b0, 1'b0, 6'h00, 8'h00);
         chk(8'(total >= lo[i] && total <= hi[i]), 8'h01);
         chk(head, (i == 0) ? 8'h1a : 8'h1e);
         chkb(pf, 4'h2);
      end
   endtask
   // save step, early finish, overlap and address step
   task s_steps();
      run(OP_DIVU_L, 1'b0, 1'b1, 6'h00, 8'h00);
      chk(total, 8'h30);
      chkb(pf, 4'h2);
      run(OP_ALT_MOVE, 1'b0, 1'b1, 6'h00, 8'h00);
      chk(total, 8'h0d);
      run(OP_ALT_MOVE, 1'b0, 1'b0, 6'h00, 8'h00);
      chk(total, 8'h0e);
      @(posedge clk) early <= 8'h0a;
      run(OP_DIVS_L, 1'b0, 1'b0, 6'h00, 8'h00);
      chk(total, 8'h34);
      @(posedge clk) early <= 8'h00;
      run(OP_DEC_MEM, 1'b0, 1'b0, 6'h00, 8'h01);
      chk(total, 8'h0b);
      chkb(rd, 4'h2);
      @(posedge clk) {eah, eat, eac} <= {8'h01, 8'h01, 8'h03};
      run(OP_DIVU_W, 1'b0, 1'b0, 6'h00, 8'h00);
      chk(total, 8'h23);
      @(posedge clk) eac <= 8'h00;
   endtask
   // slow bus: extra clocks eat the head first, then lengthen tail and total
   task s_slow();
      @(posedge clk) {acc_clk, accs} <= {4'h4, 4'h1};
      run(OP_ATOMIC_REG, 1'b0, 1'b0, 6'h00, 8'h00);
      chk(head, 8'h02);
      chk(total, 8'h06);
      @(posedge clk) {acc_clk, accs} <= {4'h5, 4'h2};
      run(OP_ATOMIC_REG, 1'b0, 1'b0, 6'h00, 8'h00);
      chk(head, 8'h00);
      chk(tail, 8'h02);
      chk(total, 8'h08);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      s_alu();
      s_fixed();
      s_shift();
      s_table();
      s_steps();
      s_slow();
      conclude();
   end
   // watchdog well beyond the less than one thousand cycles the runs need
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      conclude();
   end
endmodule
